// file: src/mpp_pkg.sv
package mpp_pkg;
  // Register offsets
  localparam logic [7:0] PIN5_CONFIG_ADDR   = 8'h77;
  localparam logic [7:0] PIN6_CONFIG_ADDR   = 8'h78;
  localparam logic [7:0] PIN7_CONFIG_ADDR   = 8'h79;
  localparam logic [7:0] PIN_IRQ_STS_ADDR   = 8'h7a;
  localparam logic [7:0] BUCK1_ROUTE_ADDR   = 8'h7b;
  localparam logic [7:0] BUCK2_ROUTE_ADDR   = 8'h7c;
  localparam logic [7:0] BUCK3_ROUTE_ADDR   = 8'h7d;
  localparam logic [7:0] USB_OK_ROUTE_ADDR  = 8'h7e;

  // Pin configuration fields
  localparam int PULL_UP_SEL_BIT     = 0;
  localparam int RESISTOR_ON_BIT     = 1;
  localparam int OUTPUT_ENABLE_BIT   = 2;
  localparam int OPEN_DRAIN_SEL_BIT  = 3;
  localparam int DRIVE_VALUE_BIT     = 4;
  localparam int PIN_LEVEL_BIT       = 7;
  localparam int CFG_W               = 5;
  localparam logic [4:0] CFG_RESET   = 5'h00;

  // Routing registers: bits 5 and 6 select pins five and six, bit 7 shows the flag
  localparam int ROUTE_FLAG_BIT      = 7;
  localparam int ROUTE_SEL_W         = 7;
  localparam int ROUTE_PIN5_BIT      = 5;
  localparam int ROUTE_PIN6_BIT      = 6;
  localparam logic [6:0] ROUTE_RESET = 7'h00;

  // Sources: 0..2 bucks, 3 usb input ok
  localparam int NUM_SRC             = 4;
  localparam int NUM_PINS            = 3;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  localparam logic [1:0] PRIME_CYCLES  = 2'h2;
endpackage : mpp_pkg

// file: src/mpp_pin_cell.sv
`timescale 1ns/10ps
module mpp_pin_cell
  import mpp_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Register write
  input  wire logic             wrEn,
  input  wire logic [7:0]       wrData,
  // Interrupt routed onto this pin
  input  wire logic             irqForce,
  // Pad
  input  wire logic             padIn,
  output logic                  padOut,
  output logic                  padOe,
  output logic                  pullUpEn,
  output logic                  pullDownEn,
  // Readback
  output logic [CFG_W-1:0]      cfgQ,
  output logic                  levelQ
);
  logic syncA_q;
  logic dir;
  logic driveVal;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfgQ <= CFG_RESET;
    end else if (wrEn) begin
      cfgQ <= wrData[CFG_W-1:0];
    end
  end

  // Pad level seen by software; released open drain reads what the far side drives, the pulls being off
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syncA_q <= 1'b0;
      levelQ  <= 1'b0;
    end else begin
      syncA_q <= padIn;
      levelQ  <= syncA_q;
    end
  end

  assign dir      = cfgQ[OUTPUT_ENABLE_BIT];
  // Routed interrupt pulls the pin low when its output is enabled, the usual active-low convention
  assign driveVal = cfgQ[DRIVE_VALUE_BIT] & ~irqForce;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      padOut     <= 1'b0;
      padOe      <= 1'b0;
      pullUpEn   <= 1'b0;
      pullDownEn <= 1'b0;
    end else begin
      padOe      <= dir & ~(cfgQ[OPEN_DRAIN_SEL_BIT] & driveVal);
      padOut     <= driveVal & ~cfgQ[OPEN_DRAIN_SEL_BIT];
      pullUpEn   <= ~dir & cfgQ[RESISTOR_ON_BIT] & cfgQ[PULL_UP_SEL_BIT];
      pullDownEn <= ~dir & cfgQ[RESISTOR_ON_BIT] & ~cfgQ[PULL_UP_SEL_BIT];
    end
  end
endmodule : mpp_pin_cell

// file: src/mpp_pin_config.sv
`timescale 1ns/10ps
module mpp_pin_config
  import mpp_pkg::*;
(
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // Register port from the serial host engine
  input  wire logic [7:0]          regAddr,
  input  wire logic [7:0]          regWrData,
  input  wire logic                regWrEn,
  input  wire logic                regRdEn,
  output logic      [7:0]          regRdData,
  output logic                     regRdValid,
  // Power-good sources: bucks 1..3, usb input ok
  input  wire logic [NUM_SRC-1:0]  powerGood,
  // Pads, index 0..2 for pins five to seven
  input  wire logic [NUM_PINS-1:0] pinIn,
  output logic      [NUM_PINS-1:0] pinOut,
  output logic      [NUM_PINS-1:0] pinOe,
  output logic      [NUM_PINS-1:0] pinPullUp,
  output logic      [NUM_PINS-1:0] pinPullDown
);
  logic [CFG_W-1:0]       cfgQ     [NUM_PINS];
  logic [NUM_PINS-1:0]    levelQ;
  logic [NUM_PINS-1:0]    cfgWr;
  logic [NUM_PINS-1:0]    irqForce;
  logic [ROUTE_SEL_W-1:0] routeSel_q [NUM_SRC];
  logic [NUM_SRC-1:0]     pgSyncA_q;
  logic [NUM_SRC-1:0]     pgSyncB_q;
  logic [NUM_SRC-1:0]     pgPrev_q;
  logic [1:0]             primeCnt_q;
  logic                   primed;
  logic [NUM_SRC-1:0]     pgChange;
  logic [NUM_SRC-1:0]     flag_q;
  logic                   stsRead;
  logic [7:0]             rdMux;

  assign cfgWr[0] = regWrEn && regAddr == PIN5_CONFIG_ADDR;
  assign cfgWr[1] = regWrEn && regAddr == PIN6_CONFIG_ADDR;
  assign cfgWr[2] = regWrEn && regAddr == PIN7_CONFIG_ADDR;

  // Pin seven has no select bit in the routing registers
  always_comb begin
    irqForce = '0;
    for (int s = 0; s < NUM_SRC; s++) begin
      irqForce[0] = irqForce[0] | (flag_q[s] & routeSel_q[s][ROUTE_PIN5_BIT]);
      irqForce[1] = irqForce[1] | (flag_q[s] & routeSel_q[s][ROUTE_PIN6_BIT]);
    end
  end

  for (genvar p = 0; p < NUM_PINS; p++) begin : gPin
    mpp_pin_cell uCell (
      .clk        (clk),
      .rst        (rst),
      .wrEn       (cfgWr[p]),
      .wrData     (regWrData),
      .irqForce   (irqForce[p]),
      .padIn      (pinIn[p]),
      .padOut     (pinOut[p]),
      .padOe      (pinOe[p]),
      .pullUpEn   (pinPullUp[p]),
      .pullDownEn (pinPullDown[p]),
      .cfgQ       (cfgQ[p]),
      .levelQ     (levelQ[p])
    );
  end

  // Routing select registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int s = 0; s < NUM_SRC; s++) routeSel_q[s] <= ROUTE_RESET;
    end else if (regWrEn) begin
      case (regAddr)
        BUCK1_ROUTE_ADDR:  routeSel_q[0] <= regWrData[ROUTE_SEL_W-1:0];
        BUCK2_ROUTE_ADDR:  routeSel_q[1] <= regWrData[ROUTE_SEL_W-1:0];
        BUCK3_ROUTE_ADDR:  routeSel_q[2] <= regWrData[ROUTE_SEL_W-1:0];
        USB_OK_ROUTE_ADDR: routeSel_q[3] <= regWrData[ROUTE_SEL_W-1:0];
        default:           ;
      endcase
    end
  end

  // Power-good inputs come from the analog domain
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pgSyncA_q <= '0;
      pgSyncB_q <= '0;
      pgPrev_q  <= '0;
    end else begin
      pgSyncA_q <= powerGood;
      pgSyncB_q <= pgSyncA_q;
      pgPrev_q  <= pgSyncB_q;
    end
  end

  // Hold off edge detection until the synchroniser holds real samples,
  // otherwise a rail already good at reset would look like a change
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      primeCnt_q <= 2'h0;
    end else if (!primed) begin
      primeCnt_q <= primeCnt_q + 2'h1;
    end
  end

  assign primed   = primeCnt_q > PRIME_CYCLES;
  assign pgChange = primed ? (pgSyncB_q ^ pgPrev_q) : '0;
  assign stsRead  = regRdEn && regAddr == PIN_IRQ_STS_ADDR;

  // Sticky flags, cleared by reading status; a new change wins over the clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_q <= '0;
    end else begin
      flag_q <= (stsRead ? '0 : flag_q) | pgChange;
    end
  end

  always_comb begin
    case (regAddr)
      PIN5_CONFIG_ADDR:  rdMux = {levelQ[0], 2'b00, cfgQ[0]};
      PIN6_CONFIG_ADDR:  rdMux = {levelQ[1], 2'b00, cfgQ[1]};
      PIN7_CONFIG_ADDR:  rdMux = {levelQ[2], 2'b00, cfgQ[2]};
      PIN_IRQ_STS_ADDR:  rdMux = {4'h0, flag_q};
      BUCK1_ROUTE_ADDR:  rdMux = {flag_q[0], routeSel_q[0]};
      BUCK2_ROUTE_ADDR:  rdMux = {flag_q[1], routeSel_q[1]};
      BUCK3_ROUTE_ADDR:  rdMux = {flag_q[2], routeSel_q[2]};
      USB_OK_ROUTE_ADDR: rdMux = {flag_q[3], routeSel_q[3]};
      default:           rdMux = READ_UNMAPPED;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regRdData  <= 8'h00;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRdEn;
      if (regRdEn) begin
        regRdData <= rdMux;
      end
    end
  end

  // Checks on pin five, then status, routing and readback checks
  chk_input_hiz: assert property (@(posedge clk) disable iff (rst)
    !cfgQ[0][OUTPUT_ENABLE_BIT] |=> !pinOe[0])
    else $error("input pin is driven");

  chk_drive_low: assert property (@(posedge clk) disable iff (rst)
    cfgQ[0][OUTPUT_ENABLE_BIT] && !cfgQ[0][DRIVE_VALUE_BIT] |=> pinOe[0] && !pinOut[0])
    else $error("output zero not driven low");

  chk_od_release: assert property (@(posedge clk) disable iff (rst)
    cfgQ[0][OUTPUT_ENABLE_BIT] && cfgQ[0][DRIVE_VALUE_BIT] && cfgQ[0][OPEN_DRAIN_SEL_BIT]
    && !irqForce[0] |=> !pinOe[0])
    else $error("open drain one not released");

  chk_pp_high: assert property (@(posedge clk) disable iff (rst)
    cfgQ[0][OUTPUT_ENABLE_BIT] && cfgQ[0][DRIVE_VALUE_BIT] && !cfgQ[0][OPEN_DRAIN_SEL_BIT]
    && !irqForce[0] |=> pinOe[0] && pinOut[0])
    else $error("push-pull one not driven high");

  chk_no_pull_out: assert property (@(posedge clk) disable iff (rst)
    cfgQ[0][OUTPUT_ENABLE_BIT] || !cfgQ[0][RESISTOR_ON_BIT] |=> !pinPullUp[0] && !pinPullDown[0])
    else $error("resistor attached when not allowed");

  chk_pull_select: assert property (@(posedge clk) disable iff (rst)
    !cfgQ[0][OUTPUT_ENABLE_BIT] && cfgQ[0][RESISTOR_ON_BIT]
    |=> pinPullUp[0] == $past(cfgQ[0][PULL_UP_SEL_BIT]) && pinPullUp[0] != pinPullDown[0])
    else $error("wrong pull direction");

  chk_change_flag: assert property (@(posedge clk) disable iff (rst)
    primed && pgSyncB_q[0] != pgPrev_q[0] |=> flag_q[0])
    else $error("power-good change not flagged");

  chk_flag_quiet: assert property (@(posedge clk) disable iff (rst)
    !flag_q[1] && $stable(pgSyncB_q[1]) && pgSyncB_q[1] == pgPrev_q[1] |=> !flag_q[1])
    else $error("flag raised without change");

  chk_status_read: assert property (@(posedge clk) disable iff (rst)
    stsRead |=> regRdValid && regRdData == {4'h0, $past(flag_q)})
    else $error("status read mismatch");

  chk_reserved_zero: assert property (@(posedge clk) disable iff (rst)
    regRdEn && regAddr == PIN6_CONFIG_ADDR |=> regRdData[6:5] == 2'b00)
    else $error("reserved bits not zero");

  chk_route_off: assert property (@(posedge clk) disable iff (rst)
    routeSel_q[0][ROUTE_PIN5_BIT] == 1'b0 && routeSel_q[1][ROUTE_PIN5_BIT] == 1'b0
    && routeSel_q[2][ROUTE_PIN5_BIT] == 1'b0 && routeSel_q[3][ROUTE_PIN5_BIT] == 1'b0
    |-> !irqForce[0])
    else $error("unrouted interrupt reached pin five");

  chk_route_drive: assert property (@(posedge clk) disable iff (rst)
    flag_q[0] && routeSel_q[0][ROUTE_PIN5_BIT] |-> irqForce[0])
    else $error("routed interrupt missing on pin five");

  chk_route_six_off: assert property (@(posedge clk) disable iff (rst)
    !routeSel_q[0][ROUTE_PIN6_BIT] && !routeSel_q[1][ROUTE_PIN6_BIT]
    && !routeSel_q[2][ROUTE_PIN6_BIT] && !routeSel_q[3][ROUTE_PIN6_BIT]
    |-> !irqForce[1])
    else $error("unrouted interrupt reached pin six");

  chk_route_six_on: assert property (@(posedge clk) disable iff (rst)
    flag_q[3] && routeSel_q[3][ROUTE_PIN6_BIT] |-> irqForce[1])
    else $error("routed interrupt missing on pin six");

  // Readback lags the pad by the two synchroniser stages
  chk_level_sync: assert property (@(posedge clk) disable iff (rst)
    primed |-> levelQ == $past(pinIn, 2))
    else $error("pin level readback wrong");

  chk_flag_sticky: assert property (@(posedge clk) disable iff (rst)
    !stsRead |=> (flag_q & $past(flag_q)) == $past(flag_q))
    else $error("flag lost without a status read");

  chk_flag_clear: assert property (@(posedge clk) disable iff (rst)
    stsRead && pgChange == '0 |=> flag_q == '0)
    else $error("flag not cleared by status read");

  chk_status_readonly: assert property (@(posedge clk) disable iff (rst)
    regWrEn && regAddr == PIN_IRQ_STS_ADDR && !stsRead && pgChange == '0
    |=> flag_q == $past(flag_q))
    else $error("status register took a write");

  chk_route_flag: assert property (@(posedge clk) disable iff (rst)
    regRdEn && regAddr == BUCK2_ROUTE_ADDR
    |=> regRdData[ROUTE_FLAG_BIT] == $past(flag_q[1]))
    else $error("routing register flag bit wrong");

  chk_reserved_others: assert property (@(posedge clk) disable iff (rst)
    regRdEn && (regAddr == PIN5_CONFIG_ADDR || regAddr == PIN7_CONFIG_ADDR)
    |=> regRdData[6:5] == 2'b00)
    else $error("reserved bits of pin five or seven not zero");

  // Same pad checks on pins six and seven
  chk_hiz_pin_six: assert property (@(posedge clk) disable iff (rst)
    !cfgQ[1][OUTPUT_ENABLE_BIT] |=> !pinOe[1])
    else $error("input pin six is driven");

  chk_low_pin_six: assert property (@(posedge clk) disable iff (rst)
    cfgQ[1][OUTPUT_ENABLE_BIT] && !cfgQ[1][DRIVE_VALUE_BIT] |=> pinOe[1] && !pinOut[1])
    else $error("pin six zero not driven low");

  chk_od_pin_six: assert property (@(posedge clk) disable iff (rst)
    cfgQ[1][OUTPUT_ENABLE_BIT] && cfgQ[1][DRIVE_VALUE_BIT] && cfgQ[1][OPEN_DRAIN_SEL_BIT]
    && !irqForce[1] |=> !pinOe[1])
    else $error("pin six open drain one not released");

  chk_pp_pin_six: assert property (@(posedge clk) disable iff (rst)
    cfgQ[1][OUTPUT_ENABLE_BIT] && cfgQ[1][DRIVE_VALUE_BIT] && !cfgQ[1][OPEN_DRAIN_SEL_BIT]
    && !irqForce[1] |=> pinOe[1] && pinOut[1])
    else $error("pin six push-pull one not driven high");

  chk_nopull_pin_six: assert property (@(posedge clk) disable iff (rst)
    cfgQ[1][OUTPUT_ENABLE_BIT] || !cfgQ[1][RESISTOR_ON_BIT]
    |=> !pinPullUp[1] && !pinPullDown[1])
    else $error("pin six resistor attached when not allowed");

  chk_sel_pin_six: assert property (@(posedge clk) disable iff (rst)
    !cfgQ[1][OUTPUT_ENABLE_BIT] && cfgQ[1][RESISTOR_ON_BIT]
    |=> pinPullUp[1] == $past(cfgQ[1][PULL_UP_SEL_BIT]) && pinPullUp[1] != pinPullDown[1])
    else $error("pin six wrong pull direction");

  chk_hiz_pin_seven: assert property (@(posedge clk) disable iff (rst)
    !cfgQ[2][OUTPUT_ENABLE_BIT] |=> !pinOe[2])
    else $error("input pin seven is driven");

  chk_low_pin_seven: assert property (@(posedge clk) disable iff (rst)
    cfgQ[2][OUTPUT_ENABLE_BIT] && !cfgQ[2][DRIVE_VALUE_BIT] |=> pinOe[2] && !pinOut[2])
    else $error("pin seven zero not driven low");

  chk_od_pin_seven: assert property (@(posedge clk) disable iff (rst)
    cfgQ[2][OUTPUT_ENABLE_BIT] && cfgQ[2][DRIVE_VALUE_BIT] && cfgQ[2][OPEN_DRAIN_SEL_BIT]
    && !irqForce[2] |=> !pinOe[2])
    else $error("pin seven open drain one not released");

  chk_pp_pin_seven: assert property (@(posedge clk) disable iff (rst)
    cfgQ[2][OUTPUT_ENABLE_BIT] && cfgQ[2][DRIVE_VALUE_BIT] && !cfgQ[2][OPEN_DRAIN_SEL_BIT]
    && !irqForce[2] |=> pinOe[2] && pinOut[2])
    else $error("pin seven push-pull one not driven high");

  chk_nopull_pin_seven: assert property (@(posedge clk) disable iff (rst)
    cfgQ[2][OUTPUT_ENABLE_BIT] || !cfgQ[2][RESISTOR_ON_BIT]
    |=> !pinPullUp[2] && !pinPullDown[2])
    else $error("pin seven resistor attached when not allowed");

  chk_sel_pin_seven: assert property (@(posedge clk) disable iff (rst)
    !cfgQ[2][OUTPUT_ENABLE_BIT] && cfgQ[2][RESISTOR_ON_BIT]
    |=> pinPullUp[2] == $past(cfgQ[2][PULL_UP_SEL_BIT]) && pinPullUp[2] != pinPullDown[2])
    else $error("pin seven wrong pull direction");
endmodule : mpp_pin_config

// file: testbench/mpp_pad_model.sv
`timescale 1ns/10ps
module mpp_pad_model
  import mpp_pkg::*;
(
  // Clock
  input  wire logic                clk,
  // Device side of the pads
  input  wire logic [NUM_PINS-1:0] pinOut,
  input  wire logic [NUM_PINS-1:0] pinOe,
  input  wire logic [NUM_PINS-1:0] pinPullUp,
  input  wire logic [NUM_PINS-1:0] pinPullDown,
  // Far-side driver, backs off where the device drives
  input  wire logic [NUM_PINS-1:0] extEn,
  input  wire logic [NUM_PINS-1:0] extLvl,
  // Resolved pad level
  output logic      [NUM_PINS-1:0] pinIn
);
  // Floating pad wanders so a settled guess cannot pass
  logic [NUM_PINS-1:0] wander = '0;
  always @(posedge clk) wander <= ~wander;
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      if (pinOe[i]) pinIn[i] = pinOut[i];
      else if (extEn[i]) pinIn[i] = extLvl[i];
      else if (pinPullUp[i]) pinIn[i] = 1'b1;
      else if (pinPullDown[i]) pinIn[i] = 1'b0;
      else pinIn[i] = wander[i];
    end
  end
endmodule : mpp_pad_model

// file: testbench/tb_multipurpose_pin_config.sv
`timescale 1ns/10ps
module tb_multipurpose_pin_config
  import mpp_pkg::*;
;
  logic                clk, rst, regWrEn, regRdEn, regRdValid;
  logic [7:0]          regAddr, regWrData, regRdData, rdv;
  logic [NUM_SRC-1:0]  powerGood;
  logic [NUM_PINS-1:0] pinIn, pinOut, pinOe, pinPullUp, pinPullDown, extEn, extLvl;
  logic                lvl;
  int                  fail_count, tests_run;
  int                  cfg [NUM_PINS];

  mpp_pin_config i_mpp_pin_config (.clk(clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .regRdValid(regRdValid), .powerGood(powerGood), .pinIn(pinIn), .pinOut(pinOut),
    .pinOe(pinOe), .pinPullUp(pinPullUp), .pinPullDown(pinPullDown));
  mpp_pad_model i_mpp_pad_model (.clk(clk), .pinOut(pinOut), .pinOe(pinOe),
    .pinPullUp(pinPullUp), .pinPullDown(pinPullDown), .extEn(extEn), .extLvl(extLvl),
    .pinIn(pinIn));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #10 regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(posedge clk);
    #10 regWrEn = 1'b0;
  endtask : wr

  // Answer is registered on the taking edge itself and read 10 ns later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #10 regAddr = a;
    regRdEn = 1'b1;
    @(posedge clk);
    #10 regRdEn = 1'b0;
    chk(8'(regRdValid), 8'h01, "read valid");
    d = regRdData;
  endtask : rd

  task automatic chk_pads(input int p);
    logic [4:0] c;
    c = 5'(cfg[p]);
    chk(8'(pinOe[p]), 8'(c[2] & ~(c[3] & c[4])), "oe");
    if (c[2] && !(c[3] && c[4])) chk(8'(pinOut[p]), 8'(c[4] & ~c[3]), "out");
    chk(8'(pinPullUp[p]), 8'(~c[2] & c[1] & c[0]), "pull up");
    chk(8'(pinPullDown[p]), 8'(~c[2] & c[1] & ~c[0]), "pull down");
  endtask : chk_pads

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run

  initial begin
    #3000000;
    $display("Watchdog expired");
    fail_count++;
    complete_run;
  end

  initial begin
    rst = 1'b1;
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    powerGood = '0;
    extEn = '1;
    extLvl = '0;
    fail_count = 0;
    tests_run = 0;
    cfg = '{0, 0, 0};
    void'($urandom(32'h1f24));
    repeat (3) @(posedge clk);
    #10 rst = 1'b0;
    chk(8'({pinOe, pinPullUp}), 8'h00, "reset pads");
    chk(8'(pinPullDown), 8'h00, "reset pull-down");
    for (int a = 0; a < 4; a++) begin
      rd(8'(PIN5_CONFIG_ADDR + a), rdv);
      chk(rdv, 8'h00, "reset value");
    end
    $display("TEST reset values done");
    for (int p = 0; p < NUM_PINS; p++) begin
      for (int k = 0; k < 32; k++) begin
        cfg[p] = k;
        wr(8'(PIN5_CONFIG_ADDR + p), {3'($urandom), 5'(k)});
        // Far side lets go only where a pull holds the pad; the far side drives a released open drain one high
        extEn = 3'($urandom) | ((k[2] || !k[1]) ? 3'(1 << p) : 3'h0);
        extLvl = 3'($urandom) | ((k[2] && k[3] && k[4]) ? 3'(1 << p) : 3'h0);
        repeat (2) @(posedge clk);
        #10 chk_pads(p);
        if (k[2] && !(k[3] && k[4])) lvl = k[4] & ~k[3];
        else if (extEn[p]) lvl = extLvl[p];
        else lvl = k[0];
        rd(8'(PIN5_CONFIG_ADDR + p), rdv);
        chk(rdv, {lvl, 2'b00, 5'(k)}, "cfg readback");
      end
    end
    $display("TEST pin config sweep done");
    wr(PIN_IRQ_STS_ADDR, 8'hff);
    rd(PIN_IRQ_STS_ADDR, rdv);
    chk(rdv, 8'h00, "status write ignored");
    rd(8'h80, rdv);
    chk(rdv, 8'h00, "unmapped read");
    $display("TEST refused access done");
    for (int s = 0; s < NUM_SRC; s++) begin
      powerGood[s] = ~powerGood[s];
      repeat (6) @(posedge clk);
      rd(PIN_IRQ_STS_ADDR, rdv);
      chk(rdv, 8'(1 << s), "flag set");
      rd(PIN_IRQ_STS_ADDR, rdv);
      chk(rdv, 8'h00, "flag cleared");
    end
    $display("TEST status flags done");
    wr(PIN5_CONFIG_ADDR, 8'h14);
    wr(BUCK1_ROUTE_ADDR, 8'h20);
    powerGood[0] = ~powerGood[0];
    repeat (6) @(posedge clk);
    #10 chk(8'({pinOe[0], pinOut[0]}), 8'h02, "routed low");
    rd(BUCK1_ROUTE_ADDR, rdv);
    chk(rdv, 8'ha0, "route readback");
    rd(PIN_IRQ_STS_ADDR, rdv);
    chk(rdv, 8'h01, "routed flag");
    repeat (2) @(posedge clk);
    #10 chk(8'({pinOe[0], pinOut[0]}), 8'h03, "route released");
    wr(PIN6_CONFIG_ADDR, 8'h1c);
    wr(USB_OK_ROUTE_ADDR, 8'h40);
    powerGood[3] = ~powerGood[3];
    repeat (6) @(posedge clk);
    #10 chk(8'({pinOe[1], pinOut[1]}), 8'h02, "open drain routed low");
    rd(PIN_IRQ_STS_ADDR, rdv);
    chk(rdv, 8'h08, "usb routed flag");
    repeat (2) @(posedge clk);
    #10 chk(8'(pinOe[1]), 8'h00, "open drain released");
    $display("TEST routing done");
    complete_run;
  end
endmodule : tb_multipurpose_pin_config
